// file: verilog/adcsb_params.svh
/*
 offsets, field positions, write masks and reset values of the
 scan and buffer control block.
 assumes word-aligned AHB-Lite access, byte offsets in 8 bits.
*/
`ifndef ADCSB_PARAMS_SVH
`define ADCSB_PARAMS_SVH
// ==========================================================
// register byte offsets
`define ADCSB_OFS_SCAN 8'h00
`define ADCSB_OFS_DMA 8'h04
`define ADCSB_OFS_MODE 8'h08
`define ADCSB_OFS_SCANLIST 8'h0C
`define ADCSB_OFS_PINFUNC 8'h10
`define ADCSB_OFS_STATUS 8'h14
`define ADCSB_OFS_MASK 8'h18
`define ADCSB_BUF_REGION 2'b01
// ==========================================================
// scan_and_buffer_control fields
`define ADCSB_SCAN_REF_HI 15
`define ADCSB_SCAN_REF_LO 13
`define ADCSB_SCAN_CSCN 10
`define ADCSB_SCAN_CHANNEL_COUNT_SELECT_HI 9
`define ADCSB_SCAN_CHANNEL_COUNT_SELECT_LO 8
`define ADCSB_SCAN_HALF 7
`define ADCSB_SCAN_SAMPLE_COUNT_PER_EVENT_HI 6
`define ADCSB_SCAN_SAMPLE_COUNT_PER_EVENT_LO 2
`define ADCSB_SCAN_SPLIT 1
`define ADCSB_SCAN_ALT 0
`define ADCSB_SCAN_WMASK 16'hE77F
// ==========================================================
// dma_buffer_control fields
`define ADCSB_DMA_EN 8
`define ADCSB_DMA_BL_HI 2
`define ADCSB_DMA_BL_LO 0
`define ADCSB_DMA_WMASK 16'h0107
// ==========================================================
// mode_control fields
`define ADCSB_MODE_ON 0
`define ADCSB_MODE_RES 1
`define ADCSB_MODE_CH0_HI 7
`define ADCSB_MODE_CH0_LO 4
`define ADCSB_MODE_WMASK 16'h00F3
// ==========================================================
// status bits and reset values
`define ADCSB_ST_CONV 0
`define ADCSB_ST_DMA 1
`define ADCSB_RST16 16'h0000
`define ADCSB_RST2 2'h0
`endif

// file: verilog/adcsb_pkg.sv
/*
 types of the scan and buffer control block.
 assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package adcsb_pkg;
  // ========================================================
  // converter result as presented by the analog core
  typedef struct packed {
    logic valid;
    logic [1:0] sh;
    logic [11:0] data;
  } adcsb_result_t;
  // ========================================================
  // sampling control towards the input multiplexer
  typedef struct packed {
    logic [3:0] sh_enable;
    logic [3:0] ch0_input;
    logic ch0_valid;
    logic alt_mux;
  } adcsb_sample_ctrl_t;
  // ========================================================
  // bus response state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RESP = 3'b100
  } adcsb_state_t;
endpackage
`default_nettype wire

// file: verilog/adcsb_buffer_mem.sv
/*
 sixteen-word result buffer, one write port, registered read.
 assumes one clock; read data appear one edge after the address.
*/
`timescale 1ns/100ps
`default_nettype none
module adcsb_buffer_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock
  input wire logic sys_clk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  // ========================================================
  // storage
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// file: verilog/adcsb_ctrl.sv
/*
 scan, sample-count and result buffer control of a SAR converter,
 with an AHB-Lite register slave and one level interrupt.
 assumes the analog core reports each conversion as a one-cycle
 valid in the sys_clk domain and the DMA engine takes dma_req.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adcsb_params.svh"
module adcsb_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // converter
  input wire adcsb_pkg::adcsb_result_t conv_result,
  output adcsb_pkg::adcsb_sample_ctrl_t sample_ctrl,
  // dma
  output logic dma_req,
  output logic [11:0] dma_data,
  output logic dma_advance,
  output logic [6:0] dma_word_index,
  // interrupt
  output logic irq
);
  // ========================================================
  // registers
  logic [15:0] scan_and_buffer_control;
  logic [15:0] dma_buffer_control;
  logic [15:0] mode_control;
  logic [15:0] scan_list;
  logic [15:0] pin_function;
  logic [1:0] status;
  logic [1:0] mask;
  logic buffer_half_status;
  logic [4:0] sample_cnt;
  logic [3:0] fill_ptr;
  logic [3:0] scan_pos;
  adcsb_pkg::adcsb_state_t state;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [11:0] mem_rdata;
  // ========================================================
  // field decode
  wire enable = mode_control[`ADCSB_MODE_ON];
  wire resolution_select = mode_control[`ADCSB_MODE_RES];
  wire [3:0] ch0_manual =
    mode_control[`ADCSB_MODE_CH0_HI:`ADCSB_MODE_CH0_LO];
  wire input_scan_select = scan_and_buffer_control[`ADCSB_SCAN_CSCN];
  wire split_buffer_mode = scan_and_buffer_control[`ADCSB_SCAN_SPLIT];
  wire [4:0] sample_count_per_event =
    scan_and_buffer_control[`ADCSB_SCAN_SAMPLE_COUNT_PER_EVENT_HI:`ADCSB_SCAN_SAMPLE_COUNT_PER_EVENT_LO];
  wire [1:0] channel_count_select_raw =
    scan_and_buffer_control[`ADCSB_SCAN_CHANNEL_COUNT_SELECT_HI:`ADCSB_SCAN_CHANNEL_COUNT_SELECT_LO];
  // hidden and read as zero in high resolution
  wire [1:0] channel_count_select = resolution_select ? 2'h0 : channel_count_select_raw;
  wire dma_result_routing_enable = dma_buffer_control[`ADCSB_DMA_EN];
  wire [2:0] dma_words_per_input =
    dma_buffer_control[`ADCSB_DMA_BL_HI:`ADCSB_DMA_BL_LO];
  // ========================================================
  // sample-and-hold selection
  wire [3:0] sh_enable = resolution_select ? 4'h1 :
    channel_count_select[1] ? 4'hF :
    channel_count_select[0] ? 4'h3 : 4'h1;
  // ========================================================
  // input selection, pins in analog-function use excluded
  wire [15:0] eff_list = scan_list & ~pin_function;
  function automatic logic [3:0] next_input(input logic [3:0] cur,
                                            input logic [15:0] list);
    logic [3:0] idx;
    logic found;
    next_input = cur;
    found = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      idx = cur + 4'(i);
      if (!found && list[idx]) begin
        next_input = idx;
        found = 1'b1;
      end
    end
  endfunction
  wire [3:0] ch0_sel = input_scan_select ? scan_pos : ch0_manual;
  wire ch0_ok = input_scan_select ? |eff_list :
    !pin_function[ch0_manual];
  // ========================================================
  // conversion accounting
  wire accept = enable && conv_result.valid;
  // top bit ignored without DMA full field with
  wire [4:0] n_limit = dma_result_routing_enable ?
    sample_count_per_event : {1'b0, sample_count_per_event[3:0]};
  wire last = accept && (sample_cnt == n_limit);
  wire conv_event = last && !dma_result_routing_enable;
  wire dma_event = last && dma_result_routing_enable;
  wire [3:0] fill_addr = split_buffer_mode ?
    {buffer_half_status, fill_ptr[2:0]} : fill_ptr;
  // word zero for DMA, else the fill pointer
  wire [3:0] mem_waddr = dma_result_routing_enable ? 4'h0 : fill_addr;
  wire [7:0] dma_words = 8'h01 << dma_words_per_input;
  wire dma_wrap = ({1'b0, dma_word_index} + 8'h01) == dma_words;
  wire scan_step = accept && input_scan_select &&
    (conv_result.sh == 2'h0);
  // ========================================================
  // bus decode
  wire take = hsel && htrans[1] && hready;
  wire do_wr = wr_pend;
  wire wr_scan = do_wr && wr_addr == `ADCSB_OFS_SCAN;
  wire wr_dma = do_wr && wr_addr == `ADCSB_OFS_DMA;
  wire wr_mode = do_wr && wr_addr == `ADCSB_OFS_MODE;
  wire wr_list = do_wr && wr_addr == `ADCSB_OFS_SCANLIST;
  wire wr_pin = do_wr && wr_addr == `ADCSB_OFS_PINFUNC;
  wire wr_stat = do_wr && wr_addr == `ADCSB_OFS_STATUS;
  wire wr_mask = do_wr && wr_addr == `ADCSB_OFS_MASK;
  wire [15:0] wd = hwdata[15:0];
  // half bit reads only in split mode
  wire [15:0] scan_rd = {scan_and_buffer_control[15:10],
    channel_count_select, split_buffer_mode && buffer_half_status,
    scan_and_buffer_control[6:0]};
  wire [15:0] reg_rd =
    rd_addr == `ADCSB_OFS_SCAN ? scan_rd :
    rd_addr == `ADCSB_OFS_DMA ? dma_buffer_control :
    rd_addr == `ADCSB_OFS_MODE ? mode_control :
    rd_addr == `ADCSB_OFS_SCANLIST ? scan_list :
    rd_addr == `ADCSB_OFS_PINFUNC ? pin_function :
    rd_addr == `ADCSB_OFS_STATUS ? {14'h0000, status} :
    rd_addr == `ADCSB_OFS_MASK ? {14'h0000, mask} :
    rd_addr[7:6] == `ADCSB_BUF_REGION ? {4'h0, mem_rdata} : 16'h0000;
  wire [1:0] st_set = {dma_event, conv_event};
  wire [1:0] st_clr = wr_stat ? wd[1:0] : 2'h0;
  // ========================================================
  // result buffer
  adcsb_buffer_mem #(.WIDTH(12), .DEPTH(16), .AW(4)) u_mem (
    .sys_clk(sys_clk),
    .we(accept),
    .waddr(mem_waddr),
    .wdata(conv_result.data),
    .raddr(haddr[5:2]),
    .rdata(mem_rdata)
  );
  // ========================================================
  // bus state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= adcsb_pkg::ST_IDLE;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= take && hwrite;
      if (take) begin
        wr_addr <= haddr[7:0];
        rd_addr <= haddr[7:0];
      end
      case (state)
        adcsb_pkg::ST_IDLE,
        adcsb_pkg::ST_RESP: begin
          state <= (take && !hwrite) ? adcsb_pkg::ST_WAIT :
            adcsb_pkg::ST_IDLE;
        end
        adcsb_pkg::ST_WAIT: begin
          hrdata <= {16'h0000, reg_rd};
          state <= adcsb_pkg::ST_RESP;
        end
        default: state <= adcsb_pkg::ST_IDLE;
      endcase
    end
  end
  assign hreadyout = state != adcsb_pkg::ST_WAIT;
  assign hresp = 1'b0;
  // ========================================================
  // software registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      scan_and_buffer_control <= `ADCSB_RST16;
      dma_buffer_control <= `ADCSB_RST16;
      mode_control <= `ADCSB_RST16;
      scan_list <= `ADCSB_RST16;
      pin_function <= `ADCSB_RST16;
      mask <= `ADCSB_RST2;
      status <= `ADCSB_RST2;
    end else begin
      // reference field kept for readback only
      if (wr_scan) scan_and_buffer_control <= wd & `ADCSB_SCAN_WMASK;
      if (wr_dma) dma_buffer_control <= wd & `ADCSB_DMA_WMASK;
      if (wr_mode) mode_control <= wd & `ADCSB_MODE_WMASK;
      if (wr_list) scan_list <= wd;
      if (wr_pin) pin_function <= wd;
      if (wr_mask) mask <= wd[1:0];
      status <= (status & ~st_clr) | st_set;
    end
  end
  assign irq = |(status & mask);
  // ========================================================
  // conversion counters
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sample_cnt <= 5'h00;
      fill_ptr <= 4'h0;
      buffer_half_status <= 1'b0;
      scan_pos <= 4'h0;
      dma_word_index <= 7'h00;
    end else if (!enable) begin
      sample_cnt <= 5'h00;
      fill_ptr <= 4'h0;
      buffer_half_status <= 1'b0;
      dma_word_index <= 7'h00;
    end else if (accept) begin
      sample_cnt <= last ? 5'h00 : sample_cnt + 5'h01;
      fill_ptr <= last ? 4'h0 : fill_ptr + 4'h1;
      if (conv_event && split_buffer_mode)
        buffer_half_status <= !buffer_half_status;
      if (dma_event)
        dma_word_index <= dma_wrap ? 7'h00 :
          dma_word_index + 7'h01;
      if (scan_step) scan_pos <= next_input(scan_pos, eff_list);
    end
  end
  // ========================================================
  // dma strobes and sampling outputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dma_req <= 1'b0;
      dma_data <= 12'h000;
      dma_advance <= 1'b0;
      sample_ctrl <= '0;
    end else begin
      dma_req <= accept && dma_result_routing_enable;
      if (accept) dma_data <= conv_result.data;
      dma_advance <= dma_event;
      sample_ctrl.sh_enable <= enable ? sh_enable : 4'h0;
      sample_ctrl.ch0_input <= ch0_sel;
      sample_ctrl.ch0_valid <= enable && ch0_ok;
      sample_ctrl.alt_mux <=
        scan_and_buffer_control[`ADCSB_SCAN_ALT];
    end
  end
  // ========================================================
  // checks
  property p_single_sh;
    @(posedge sys_clk) disable iff (!resetn)
    resolution_select |=> sample_ctrl.sh_enable[3:1] == 3'h0;
  endproperty
  a_single_sh: assert property (p_single_sh)
    else $error("extra sample-and-hold in high resolution");
  property p_pin_blocked;
    @(posedge sys_clk) disable iff (!resetn)
    (!input_scan_select && pin_function[ch0_manual])
      |=> !sample_ctrl.ch0_valid;
  endproperty
  a_pin_blocked: assert property (p_pin_blocked)
    else $error("analog-function pin offered for conversion");
  property p_scan_hold;
    @(posedge sys_clk) disable iff (!resetn)
    !input_scan_select |=> sample_ctrl.ch0_input == $past(ch0_manual);
  endproperty
  a_scan_hold: assert property (p_scan_hold)
    else $error("channel zero input moved without scanning");
  property p_channel_count_select_four;
    @(posedge sys_clk) disable iff (!resetn)
    (enable && !resolution_select && channel_count_select_raw[1])
      |=> sample_ctrl.sh_enable == 4'hF;
  endproperty
  a_channel_count_select_four: assert property (p_channel_count_select_four)
    else $error("channel count 1x did not enable four");
  property p_channel_count_select_hidden;
    @(posedge sys_clk) disable iff (!resetn)
    resolution_select |-> scan_rd[9:8] == 2'h0;
  endproperty
  a_channel_count_select_hidden: assert property (p_channel_count_select_hidden)
    else $error("channel count visible in high resolution");
  property p_half_read;
    @(posedge sys_clk) disable iff (!resetn)
    !split_buffer_mode |-> !scan_rd[7];
  endproperty
  a_half_read: assert property (p_half_read)
    else $error("half bit set outside split mode");
  property p_irq_count;
    @(posedge sys_clk) disable iff (!resetn)
    (conv_event && mask[0]) |=> irq && status[0];
  endproperty
  a_irq_count: assert property (p_irq_count)
    else $error("conversion event did not raise interrupt");
  property p_dma_adv;
    @(posedge sys_clk) disable iff (!resetn)
    (accept && dma_result_routing_enable && sample_cnt == n_limit)
      |=> dma_advance ##1 (dma_advance == $past(dma_event));
  endproperty
  a_dma_adv: assert property (p_dma_adv)
    else $error("dma advance not a single pulse");
  property p_dma_word0;
    @(posedge sys_clk) disable iff (!resetn)
    (accept && dma_result_routing_enable) |-> mem_waddr == 4'h0
      ##1 dma_req;
  endproperty
  a_dma_word0: assert property (p_dma_word0)
    else $error("dma result not in word zero");
  property p_half_toggle;
    @(posedge sys_clk) disable iff (!resetn)
    (conv_event && split_buffer_mode)
      |=> buffer_half_status != $past(buffer_half_status);
  endproperty
  a_half_toggle: assert property (p_half_toggle)
    else $error("buffer half did not toggle");
  c_irq: cover property (@(posedge sys_clk) disable iff (!resetn)
    conv_event ##1 irq);
  c_wrap: cover property (@(posedge sys_clk) disable iff (!resetn)
    dma_event && dma_wrap);
  c_read: cover property (@(posedge sys_clk) disable iff (!resetn)
    state == adcsb_pkg::ST_WAIT ##1 hreadyout);
endmodule
`default_nettype wire

// file: verif/adcsb_conv_model.sv
/*
 stand-in for the converter core and input multiplexer: emits counted
 bursts of results, sh following the enabled sample-and-holds.
 assumes one sys_clk domain and the controller's sample_ctrl.
*/
`timescale 1ns/100ps
`default_nettype none
module adcsb_conv_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // burst request
  input wire logic start,
  input wire logic [7:0] count,
  input wire logic [11:0] base,
  input wire logic slow,
  output logic busy,
  // converter side
  input wire adcsb_pkg::adcsb_sample_ctrl_t sample_ctrl,
  output adcsb_pkg::adcsb_result_t conv_result
);
  logic [7:0] left;
  logic [11:0] k;
  logic gap;
  logic [1:0] cur;
  logic [1:0] next_cur;
  // ======================================================
  // hold rotation, only enabled holds sample
  assign next_cur = (cur < 2'd3 && sample_ctrl.sh_enable[cur + 2'd1])
    ? cur + 2'd1 : 2'd0;
  assign busy = (left != 8'h00);
  // ======================================================
  // result pulses; idle data lines keep changing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      left <= 8'h00;
      k <= 12'h000;
      gap <= 1'b0;
      cur <= 2'd0;
      conv_result <= '0;
    end else begin
      gap <= slow & ~gap;
      conv_result.valid <= 1'b0;
      conv_result.data <= ~conv_result.data;
      if (start) begin
        left <= count;
        k <= 12'h000;
      end else if (busy && !gap) begin
        conv_result.valid <= 1'b1;
        conv_result.data <= base + k;
        conv_result.sh <= cur;
        cur <= next_cur;
        k <= k + 12'h001;
        left <= left - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/tb_adc_channel_scan_buffer_ctrl.sv
/*
 self-checking bench of the scan and buffer controller.
 assumes the converter model beside it and a single bus slave.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  errors++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_adc_channel_scan_buffer_ctrl;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } adcsb_row_t;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hready;
  logic hreadyout, hresp, dma_req, dma_advance, irq, busy;
  logic [31:0] hrdata, q;
  adcsb_pkg::adcsb_result_t conv_result;
  adcsb_pkg::adcsb_sample_ctrl_t sample_ctrl;
  logic [11:0] dma_data;
  logic [6:0] dma_word_index;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic [11:0] base = 12'h000;
  logic [3:0] prev;
  int errors = 0;
  int n_compared = 0;
  int n_req = 0;
  int n_adv = 0;
  adcsb_row_t rows[10] = '{
    '{1'b0, 8'h00, 16'h0000, 16'h0000}, '{1'b0, 8'h14, 16'h0000, 16'h0000},
    '{1'b1, 8'h04, 16'hFFFF, 16'h0107}, '{1'b1, 8'h00, 16'hFFFF, 16'hE77F},
    '{1'b1, 8'h08, 16'h00F2, 16'h00F2}, '{1'b0, 8'h00, 16'h0000, 16'hE47F},
    '{1'b1, 8'h08, 16'h0000, 16'h0000}, '{1'b1, 8'h20, 16'hFFFF, 16'h0000},
    '{1'b1, 8'h18, 16'hFFFF, 16'h0003}, '{1'b1, 8'h0C, 16'h00F0, 16'h00F0}};
  logic [3:0] sh_exp[4] = '{4'h1, 4'h3, 4'hF, 4'hF};
  assign hready = hreadyout;
  adcsb_ctrl dut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .conv_result(conv_result),
    .sample_ctrl(sample_ctrl), .dma_req(dma_req), .dma_data(dma_data),
    .dma_advance(dma_advance), .dma_word_index(dma_word_index), .irq(irq));
  adcsb_conv_model far (.sys_clk(sys_clk), .resetn(resetn), .start(start),
    .count(cnt), .base(base), .slow(slow), .busy(busy),
    .sample_ctrl(sample_ctrl), .conv_result(conv_result));
  // ======================================================
  // clock, pulse counters, watchdog
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (dma_req === 1'b1) n_req++;
    if (dma_advance === 1'b1) n_adv++;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end
  // ======================================================
  // bus and burst tasks
  task automatic wait_ready();
    int t;
    t = 0;
    do begin
      @(negedge sys_clk);
      t++;
    end while (hreadyout !== 1'b1 && t < 50);
    if (hreadyout !== 1'b1) errors++;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    wait_ready();
    @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    wait_ready();
    q = hrdata;
    @(posedge sys_clk);
  endtask
  task automatic burst(input logic [7:0] n, input logic [11:0] b);
    int t;
    start <= 1'b1;
    cnt <= n;
    base <= b;
    @(posedge sys_clk);
    start <= 1'b0;
    t = 0;
    do begin
      @(negedge sys_clk);
      t++;
    end while (busy === 1'b1 && t < 500);
    if (busy === 1'b1) errors++;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ======================================================
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      if (rows[i].w) ahb(1'b1, rows[i].a, rows[i].d);
      ahb(1'b0, rows[i].a, 16'h0000);
      `CHK("reg", rows[i].e, q[15:0])
    end
    // interrupt every second result, split halves
    ahb(1'b1, 8'h04, 16'h0000);
    ahb(1'b1, 8'h18, 16'h0001);
    ahb(1'b1, 8'h00, 16'h0046);
    ahb(1'b1, 8'h08, 16'h0001);
    burst(8'd2, 12'h300);
    `CHK("irq", 1'b1, irq)
    ahb(1'b0, 8'h14, 16'h0000);
    `CHK("status", 32'h0000_0001, q)
    ahb(1'b0, 8'h00, 16'h0000);
    `CHK("half", 16'h00C6, q[15:0])
    ahb(1'b0, 8'h44, 16'h0000);
    `CHK("word1", 12'h301, q[11:0])
    ahb(1'b1, 8'h14, 16'h0001);
    @(posedge sys_clk);
    `CHK("irq clr", 1'b0, irq)
    burst(8'd1, 12'h310);
    `CHK("irq early", 1'b0, irq)
    burst(8'd1, 12'h311);
    ahb(1'b0, 8'h64, 16'h0000);
    `CHK("word9", 12'h311, q[11:0])
    ahb(1'b0, 8'h00, 16'h0000);
    `CHK("half back", 16'h0046, q[15:0])
    ahb(1'b1, 8'h14, 16'h0001);
    ahb(1'b1, 8'h18, 16'h0000);
    ahb(1'b1, 8'h00, 16'h0044);
    burst(8'd2, 12'h320);
    `CHK("masked", 1'b0, irq)
    ahb(1'b0, 8'h00, 16'h0000);
    `CHK("no split", 16'h0044, q[15:0])
    // dma routing, 18 results per advance, two words per input
    ahb(1'b1, 8'h08, 16'h0000);
    ahb(1'b1, 8'h14, 16'h0003);
    ahb(1'b1, 8'h04, 16'h0101);
    ahb(1'b1, 8'h18, 16'h0003);
    ahb(1'b1, 8'h08, 16'h0001);
    n_req = 0;
    n_adv = 0;
    slow <= 1'b1;
    burst(8'd17, 12'h400);
    `CHK("adv early", 0, n_adv)
    burst(8'd1, 12'h411);
    `CHK("adv", 1, n_adv)
    `CHK("req", 18, n_req)
    `CHK("index", 7'd1, dma_word_index)
    `CHK("dma irq", 1'b1, irq)
    `CHK("dma data", 12'h411, dma_data)
    ahb(1'b0, 8'h40, 16'h0000);
    `CHK("word0", 12'h411, q[11:0])
    slow <= 1'b0;
    burst(8'd18, 12'h500);
    `CHK("wrap", 7'd0, dma_word_index)
    // channel count codes and high resolution
    ahb(1'b1, 8'h04, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      ahb(1'b1, 8'h00, 16'(c << 8));
      repeat (2) @(posedge sys_clk);
      `CHK("sh en", sh_exp[c], sample_ctrl.sh_enable)
    end
    ahb(1'b1, 8'h08, 16'h0000); // off first
    ahb(1'b1, 8'h08, 16'h0002);
    ahb(1'b1, 8'h08, 16'h0003);
    repeat (2) @(posedge sys_clk);
    `CHK("hi res sh", 4'h1, sample_ctrl.sh_enable)
    ahb(1'b0, 8'h00, 16'h0000);
    `CHK("hi res channel_count_select", 16'h0000, q[15:0])
    // scan through list, pin-shared input excluded
    ahb(1'b1, 8'h08, 16'h0002); // off first
    ahb(1'b1, 8'h08, 16'h0000);
    ahb(1'b1, 8'h0C, 16'h0016); // inputs 1, 2 and 4 listed
    ahb(1'b1, 8'h10, 16'h0004);
    ahb(1'b1, 8'h00, 16'h0400);
    ahb(1'b1, 8'h08, 16'h0051);
    prev = 4'h0;
    for (int i = 0; i < 4; i++) begin
      burst(8'd1, 12'h600);
      `CHK("scan ok", 1'b1, sample_ctrl.ch0_input inside {4'h1, 4'h4})
      `CHK("scan step", 1'b1, sample_ctrl.ch0_input !== prev)
      prev = sample_ctrl.ch0_input;
    end
    ahb(1'b1, 8'h00, 16'h0001);
    repeat (2) @(posedge sys_clk);
    `CHK("no scan", 4'h5, sample_ctrl.ch0_input)
    `CHK("alt mux", 1'b1, sample_ctrl.alt_mux)
    ahb(1'b1, 8'h08, 16'h0021);
    repeat (2) @(posedge sys_clk);
    `CHK("pin blocked", 1'b0, sample_ctrl.ch0_valid)
    // reset in mid-run with status pending
    ahb(1'b1, 8'h18, 16'h0003);
    burst(8'd1, 12'h700);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK("rst irq", 1'b0, irq)
    resetn <= 1'b1;
    @(posedge sys_clk);
    ahb(1'b0, 8'h08, 16'h0000);
    `CHK("rst mode", 16'h0000, q[15:0])
    tally_and_finish();
  end
endmodule
`default_nettype wire
